// file: hce_host_cmd_exec.sv
module hce_host_cmd_exec #(
  parameter int AW             = 16,
  parameter int SAVE_BATT_CYC  = hce_pkg::SAVE_BATT_CYC,
  parameter int SAVE_FLASH_CYC = hce_pkg::SAVE_FLASH_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        save_inhibit_jumper,
  input  wire logic        restore_inhibit_jumper,
  input  wire logic [4:0]  cs_fault_code,
  input  wire logic        line_valid,
  input  wire logic [1:0]  line_kind,
  output logic             line_exec,
  output logic             motion_run,
  output logic             step_mode,
  output logic      [31:0] logic_prog_active,
  output logic             bg_hold,
  output logic             cmd_ack
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_PK_RD = 3'b001, ST_PK_LD = 3'b010,
    ST_PK_HOLD = 3'b011, ST_STEP = 3'b100, ST_SAVE = 3'b101
  } hce_state_t;

  hce_state_t        st;
  hce_pkg::hce_cmd_t cmd;
  hce_pkg::hce_cmd_t nc;
  hce_pkg::hce_cfg_t cfg;
  hce_pkg::hce_cfg_t nv_cfg;
  logic              nv_valid;
  logic [31:0]       nv_run;
  logic [31:0]       nv_pause;
  logic [15:0]       addr;
  logic [16:0]       range;
  logic [31:0]       lmask;
  logic [31:0]       sel;
  logic [31:0]       run_m;
  logic [31:0]       pause_m;
  logic [31:0]       buf_mask;
  logic              buf_pend;
  logic              ack;
  logic              err;
  logic [4:0]        errc;
  logic              refused;
  logic              rply_v;
  logic              in_grp;
  logic              grp_next;
  logic              step_end;
  logic              rst_pend;
  logic [4:0]        pk_cnt;
  logic [15:0]       pk_addr;
  logic [31:0]       rply_lo;
  logic [31:0]       rply_hi;
  logic [31:0]       save_cnt;
  logic [47:0]       mem_q;
  logic [63:0]       fmt_word;
  logic [31:0]       next_prdata;
  logic              next_slverr;
  logic              wr;
  logic              rd;
  logic              wr_cmd;
  logic              go;
  logic              pop;
  logic              rej;
  logic [4:0]        rej_code;
  logic              long_op;
  logic              fin;

  function automatic logic [31:0] range_mask(input logic [16:0] r);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 32; i++)
      if (r[hce_pkg::RANGE_EN_BIT] && 5'(i) >= r[4:0] && 5'(i) <= r[12:8])
        m[i] = 1'b1;
    return m;
  endfunction : range_mask

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign wr     = psel && penable && pready && pwrite;
  assign rd     = psel && penable && pready && !pwrite;
  assign wr_cmd = wr && paddr == hce_pkg::A_CMD;
  assign go     = wr_cmd && st == ST_IDLE && !rst_pend;
  assign pop    = rd && paddr == hce_pkg::A_RPLLO;
  assign nc     = hce_pkg::hce_cmd_t'(pwdata[10:0]);
  assign sel    = lmask | range_mask(range);

  always_comb
  begin
    next_slverr = 1'b0;
    next_prdata = 32'h0;
    if (paddr == hce_pkg::A_CMD)
      next_prdata = {21'h0, cmd};
    else if (paddr == hce_pkg::A_ADDR)
      next_prdata = {16'h0, addr};
    else if (paddr == hce_pkg::A_RANGE)
      next_prdata = {15'h0, range};
    else if (paddr == hce_pkg::A_MASK)
      next_prdata = lmask;
    else if (paddr == hce_pkg::A_CFG)
      next_prdata = {25'h0, cfg};
    else if (paddr == hce_pkg::A_STAT)
      next_prdata = {17'h0, buf_pend, errc, nv_valid, motion_run, step_mode,
                     bg_hold, refused, rply_v, err, ack, st != ST_IDLE};
    else if (paddr == hce_pkg::A_RPLLO)
      next_prdata = rply_lo;
    else if (paddr == hce_pkg::A_RPLHI)
      next_prdata = rply_hi;
    else if (paddr == hce_pkg::A_MEMX || paddr == hce_pkg::A_MEMY)
      next_prdata = 32'h0;
    else if (paddr == hce_pkg::A_BUFQ)
      next_prdata = buf_mask;
    else if (paddr == hce_pkg::A_PRUN)
      next_prdata = run_m;
    else if (paddr == hce_pkg::A_PPAUS)
      next_prdata = pause_m;
    else
      next_slverr = 1'b1;
  end

  // Answer is sampled in setup, so every access has no wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      prdata  <= next_prdata;
      pslverr <= psel && !penable && next_slverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd   <= '0;
      addr  <= 16'h0;
      range <= 17'h0;
      lmask <= 32'h0;
    end
    else
    begin
      if (go)
        cmd <= nc;
      if (wr && paddr == hce_pkg::A_ADDR)
        addr <= pwdata[15:0];
      if (wr && paddr == hce_pkg::A_RANGE)
        range <= {pwdata[16], 3'h0, pwdata[12:8], 3'h0, pwdata[4:0]};
      if (wr && paddr == hce_pkg::A_MASK)
        lmask <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Setup, restore and non-volatile copy
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_pend <= 1'b1;
      cfg      <= hce_pkg::CFG_RST;
    end
    else
    begin
      rst_pend <= 1'b0;
      if (rst_pend && !restore_inhibit_jumper && nv_valid)
        cfg <= nv_cfg;
      else if (wr && paddr == hce_pkg::A_CFG)
        cfg <= hce_pkg::hce_cfg_t'(pwdata[6:0]);
    end
  end

  // Survives the bus reset; only power-on clears it
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      nv_valid <= 1'b0;
      nv_cfg   <= hce_pkg::CFG_RST;
      nv_run   <= 32'h0;
      nv_pause <= 32'h0;
    end
    else if (st == ST_SAVE && save_cnt == 32'h0)
    begin
      nv_valid <= 1'b1;
      nv_cfg   <= cfg;
      if (cfg.flash)
      begin
        nv_run   <= run_m;
        nv_pause <= pause_m;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    rej      = 1'b0;
    rej_code = cs_fault_code;
    long_op  = 1'b0;
    if (nc.op == hce_pkg::OP_PEEK)
    begin
      rej      = nc.count > hce_pkg::MAX_COUNT || nc.space == hce_pkg::SP_BAD;
      rej_code = hce_pkg::ERR_BAD_ARG;
      long_op  = !rej;
    end
    else if (nc.op == hce_pkg::OP_RUN || nc.op == hce_pkg::OP_STEP)
    begin
      rej     = cs_fault_code != 5'h00;
      long_op = !rej && nc.op == hce_pkg::OP_STEP && !motion_run;
    end
    else if (nc.op == hce_pkg::OP_SAVE)
    begin
      rej      = save_inhibit_jumper;
      rej_code = hce_pkg::ERR_SAVE_IN;
      long_op  = !rej;
    end
  end

  always_comb
  begin
    grp_next = in_grp;
    if (line_kind == hce_pkg::LK_GOPEN)
      grp_next = 1'b1;
    else if (line_kind == hce_pkg::LK_GCLOSE)
      grp_next = 1'b0;
  end

  // Outside a group, one line per step at granularity one, else up to the next move
  assign step_end = st == ST_STEP && line_valid && !line_exec && !grp_next
                 && (cfg.gran || line_kind == hce_pkg::LK_MOVE);

  assign fin = (go && !long_op)
            || (st == ST_PK_HOLD && pop && pk_cnt == 5'h01)
            || step_end
            || (st == ST_SAVE && save_cnt == 32'h0);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st        <= ST_IDLE;
      pk_cnt    <= 5'h0;
      pk_addr   <= 16'h0;
      save_cnt  <= 32'h0;
      in_grp    <= 1'b0;
      line_exec <= 1'b0;
    end
    else
    begin
      line_exec <= st == ST_STEP && line_valid && !line_exec;
      case (st)
        ST_IDLE:
        begin
          in_grp <= 1'b0;
          if (go && long_op && nc.op == hce_pkg::OP_PEEK)
          begin
            st      <= ST_PK_RD;
            pk_addr <= addr;
            pk_cnt  <= nc.count == 5'h00 ? hce_pkg::DEF_COUNT : nc.count;
          end
          else if (go && long_op && nc.op == hce_pkg::OP_STEP)
            st <= ST_STEP;
          else if (go && long_op)
          begin
            st       <= ST_SAVE;
            save_cnt <= cfg.flash ? 32'(SAVE_FLASH_CYC) : 32'(SAVE_BATT_CYC);
          end
        end
        ST_PK_RD:
          st <= ST_PK_LD;
        ST_PK_LD:
          st <= ST_PK_HOLD;
        ST_PK_HOLD:
          if (pop)
          begin
            pk_cnt  <= pk_cnt - 5'h01;
            pk_addr <= pk_addr + 16'h0001;
            st      <= pk_cnt == 5'h01 ? ST_IDLE : ST_PK_RD;
          end
        ST_STEP:
          if (line_valid && !line_exec)
          begin
            in_grp <= grp_next;
            if (step_end)
              st <= ST_IDLE;
          end
        ST_SAVE:
          if (save_cnt == 32'h0)
            st <= ST_IDLE;
          else
            save_cnt <= save_cnt - 32'h1;
        default:
          st <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Peek datapath
  // ----------------------------------------------------------------
  hce_xy_mem #(.AW(AW)) u_mem (
    .pclk  (pclk),
    .we_x  (wr && paddr == hce_pkg::A_MEMX),
    .we_y  (wr && paddr == hce_pkg::A_MEMY),
    .waddr (addr[AW-1:0]),
    .wdata (pwdata[23:0]),
    .raddr (pk_addr[AW-1:0]),
    .rdata (mem_q)
  );

  hce_word_fmt u_fmt (
    .raw   (mem_q),
    .space (cmd.space),
    .hex   (cmd.hex),
    .word  (fmt_word)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rply_v  <= 1'b0;
      rply_lo <= 32'h0;
      rply_hi <= 32'h0;
    end
    else if (st == ST_PK_LD)
    begin
      rply_v  <= 1'b1;
      rply_lo <= fmt_word[31:0];
      rply_hi <= fmt_word[63:32];
    end
    else if (pop)
      rply_v <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Logic programs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_m    <= 32'h0;
      pause_m  <= 32'h0;
      buf_mask <= 32'h0;
      buf_pend <= 1'b0;
    end
    else if (rst_pend && !restore_inhibit_jumper && nv_valid && nv_cfg.flash)
    begin
      run_m   <= nv_run;
      pause_m <= nv_pause;
    end
    else if (go && nc.op == hce_pkg::OP_RESUME && cfg.buf_open)
    begin
      buf_mask <= sel;
      buf_pend <= 1'b1;
    end
    else if (go && nc.op == hce_pkg::OP_RESUME)
    begin
      run_m   <= run_m | (sel & pause_m);
      pause_m <= pause_m & ~sel;
    end
    else if (go && nc.op == hce_pkg::OP_SUSPEND)
    begin
      pause_m <= pause_m | sel;
      run_m   <= run_m & ~sel;
    end
    else if (go && nc.op == hce_pkg::OP_HALT)
    begin
      run_m   <= run_m & ~sel;
      pause_m <= pause_m & ~sel;
    end
  end

  // Lags the save state by one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      logic_prog_active <= 32'h0;
      bg_hold           <= 1'b0;
    end
    else
    begin
      logic_prog_active <= run_m & {32{cfg.permit[1]}} & {32{st != ST_SAVE}};
      bg_hold           <= st == ST_SAVE;
    end
  end

  // ----------------------------------------------------------------
  // Motion program and status
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      motion_run <= 1'b0;
      step_mode  <= 1'b0;
    end
    else if (go && !rej && nc.op == hce_pkg::OP_RUN)
    begin
      motion_run <= 1'b1;
      step_mode  <= 1'b0;
    end
    else if (go && !rej && nc.op == hce_pkg::OP_STEP)
    begin
      motion_run <= 1'b0;
      step_mode  <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack     <= 1'b0;
      err     <= 1'b0;
      errc    <= 5'h0;
      refused <= 1'b0;
      cmd_ack <= 1'b0;
    end
    else
    begin
      cmd_ack <= fin;
      if (go)
      begin
        err  <= rej;
        errc <= rej && cfg.err_mode[0] ? rej_code : 5'h00;
      end
      if (go && !fin)
        ack <= 1'b0;
      else if (fin)
        ack <= 1'b1;
      if (wr && paddr == hce_pkg::A_STAT && pwdata[hce_pkg::STAT_REFUSED_BIT])
        refused <= 1'b0;
      if (wr_cmd && !go)
        refused <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_save_go;
    go && nc.op == hce_pkg::OP_SAVE;
  endsequence
  sequence s_step_go;
    go && nc.op == hce_pkg::OP_STEP;
  endsequence

  peek_count_a: assert property (go && nc.op == hce_pkg::OP_PEEK && !rej && nc.count == 5'h00
    |=> pk_cnt == 5'h01 && st == ST_PK_RD) else $error("omitted count not one");
  long_word_a: assert property (st == ST_PK_LD && cmd.space == hce_pkg::SP_L && cmd.hex
    |=> {rply_hi[15:0], rply_lo} == $past(mem_q) && rply_hi[31:16] == 16'h0) else $error("long word wrong");
  dec_sign_a: assert property (st == ST_PK_LD && cmd.space == hce_pkg::SP_X && !cmd.hex
    |=> rply_lo[23:0] == $past(mem_q[47:24]) && rply_hi == {32{$past(mem_q[47])}}) else $error("sign lost");
  resume_paused_a: assert property (go && nc.op == hce_pkg::OP_RESUME && !cfg.buf_open && !rst_pend
    |=> run_m == ($past(run_m) | ($past(sel) & $past(pause_m)))) else $error("resume set wrong");
  buf_store_a: assert property (go && nc.op == hce_pkg::OP_RESUME && cfg.buf_open
    |=> $stable(run_m) && buf_mask == $past(sel) && buf_pend) else $error("resume not buffered");
  permit_gate_a: assert property (logic_prog_active != 32'h0 |-> $past(cfg.permit[1]))
    else $error("program ran without permit");
  step_err_a: assert property (s_step_go ##0 rej
    |=> err && st == ST_IDLE && errc == ($past(cfg.err_mode[0]) ? $past(cs_fault_code) : 5'h00))
    else $error("step reject wrong");
  step_quit_a: assert property (s_step_go ##0 (!rej && motion_run)
    |=> !motion_run && step_mode && st == ST_IDLE && ack) else $error("step not quit");
  group_hold_a: assert property (st == ST_STEP && in_grp && line_valid && !line_exec
    && line_kind != hce_pkg::LK_GCLOSE |=> st == ST_STEP) else $error("group split");
  save_refuse_a: assert property (s_save_go ##0 save_inhibit_jumper
    |=> err && st == ST_IDLE && !bg_hold) else $error("save not refused");
  save_ack_a: assert property (s_save_go ##0 !rej |=> !cmd_ack throughout (st == ST_SAVE))
    else $error("early save ack");
  save_wait_a: assert property (st == ST_SAVE && save_cnt != 32'h0 |=> !cmd_ack && st == ST_SAVE)
    else $error("save ack before store done");
  save_hold_a: assert property ((st == ST_SAVE) [*2] |-> bg_hold && logic_prog_active == 32'h0)
    else $error("programs ran in save");
  restore_skip_a: assert property (rst_pend && restore_inhibit_jumper |=> cfg == hce_pkg::CFG_RST)
    else $error("restore not skipped");
endmodule : hce_host_cmd_exec

// file: hce_pkg.sv
package hce_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CMD   = 8'h00;
  localparam logic [7:0] A_ADDR  = 8'h04;
  localparam logic [7:0] A_RANGE = 8'h08;
  localparam logic [7:0] A_MASK  = 8'h0C;
  localparam logic [7:0] A_CFG   = 8'h10;
  localparam logic [7:0] A_STAT  = 8'h14;
  localparam logic [7:0] A_RPLLO = 8'h18;
  localparam logic [7:0] A_RPLHI = 8'h1C;
  localparam logic [7:0] A_MEMX  = 8'h20;
  localparam logic [7:0] A_MEMY  = 8'h24;
  localparam logic [7:0] A_BUFQ  = 8'h28;
  localparam logic [7:0] A_PRUN  = 8'h2C;
  localparam logic [7:0] A_PPAUS = 8'h30;
  localparam int         STAT_REFUSED_BIT = 4;
  localparam int         RANGE_EN_BIT     = 16;
  // ----------------------------------------------------------------
  // Values and limits
  // ----------------------------------------------------------------
  localparam logic [4:0] MAX_COUNT   = 5'h10;
  localparam logic [4:0] DEF_COUNT   = 5'h01;
  localparam logic [4:0] ERR_BAD_ARG = 5'h1E;
  localparam logic [4:0] ERR_SAVE_IN = 5'h1F;
  localparam logic [6:0] CFG_RST     = 7'h00;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 20_000_000;
  localparam int SAVE_BATT_MS   = 100;
  localparam int SAVE_FLASH_MS  = 10000;
  localparam int SAVE_BATT_CYC  = SAVE_BATT_MS * (CLK_HZ / 1000);
  localparam int SAVE_FLASH_CYC = SAVE_FLASH_MS * (CLK_HZ / 1000);
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_PEEK = 3'b001, OP_RESUME = 3'b010,
    OP_SUSPEND = 3'b011, OP_HALT = 3'b100, OP_RUN = 3'b101,
    OP_STEP = 3'b110, OP_SAVE = 3'b111
  } hce_op_t;
  typedef enum logic [1:0] {
    SP_X = 2'b00, SP_Y = 2'b01, SP_L = 2'b10, SP_BAD = 2'b11
  } hce_space_t;
  typedef enum logic [1:0] {
    LK_PLAIN = 2'b00, LK_MOVE = 2'b01, LK_GOPEN = 2'b10, LK_GCLOSE = 2'b11
  } hce_line_t;
  typedef struct packed {
    hce_op_t    op;
    logic       hex;
    hce_space_t space;
    logic [4:0] count;
  } hce_cmd_t;
  typedef struct packed {
    logic       flash;
    logic       buf_open;
    logic [1:0] permit;
    logic [1:0] err_mode;
    logic       gran;
  } hce_cfg_t;
endpackage : hce_pkg

// file: hce_xy_mem.sv
module hce_xy_mem #(
  parameter int AW = 16
) (
  input  wire logic          pclk,
  input  wire logic          we_x,
  input  wire logic          we_y,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [23:0]   wdata,
  input  wire logic [AW-1:0] raddr,
  output logic [47:0]        rdata
);
  logic [23:0] xm [2**AW];
  logic [23:0] ym [2**AW];

  always_ff @(posedge pclk)
  begin
    if (we_x)
      xm[waddr] <= wdata;
    if (we_y)
      ym[waddr] <= wdata;
    rdata <= {xm[raddr], ym[raddr]};
  end
endmodule : hce_xy_mem

// file: hce_word_fmt.sv
module hce_word_fmt (
  input  wire logic               [47:0] raw,
  input  wire hce_pkg::hce_space_t       space,
  input  wire logic                      hex,
  output logic                    [63:0] word
);
  always_comb
  begin
    if (space == hce_pkg::SP_L)
      word = hex ? {16'h0, raw} : {{16{raw[47]}}, raw};
    else if (space == hce_pkg::SP_X)
      word = hex ? {40'h0, raw[47:24]} : {{40{raw[47]}}, raw[47:24]};
    else
      word = hex ? {40'h0, raw[23:0]} : {{40{raw[23]}}, raw[23:0]};
  end
endmodule : hce_word_fmt

// file: hce_eng_model.sv
module hce_eng_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] prog,
  input  wire logic        line_exec,
  output logic             line_valid,
  output logic [1:0]       line_kind,
  output logic [3:0]       done_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] gap;
  // ----------------------------------------
  // Line presenter
  // ----------------------------------------
  // Random refill gap, so the stepper sees both prompt and slow lines
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_valid <= 1'b0;
      done_cnt   <= 4'h0;
      gap        <= 2'h0;
    end
    else if (line_exec)
    begin
      line_valid <= 1'b0;
      done_cnt   <= done_cnt + 4'h1;
      gap        <= 2'($urandom);
    end
    else if (gap != 2'h0)
      gap <= gap - 2'h1;
    else
      line_valid <= 1'b1;
  end
  // Kind is junk while no line is offered
  assign line_kind = line_valid ? prog[2*done_cnt +: 2] : ~prog[2*done_cnt +: 2];
endmodule : hce_eng_model

// file: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        sv_inh = 0, rs_inh = 0, want = 0;
  logic [7:0]  paddr = 0;
  logic [4:0]  fault = 0;
  logic [31:0] pwdata = 0, prdata, rv, active;
  logic        pready, pslverr, lexec, lvalid, mrun, smode, bgh, ack;
  logic [1:0]  lkind;
  logic [3:0]  ncnt;
  logic [23:0] xs [2], ys [2];
  logic [47:0] r;
  logic [63:0] e, w, q [$];
  int          failures = 0, check_count = 0, n, k;
  hce_host_cmd_exec #(.AW(6), .SAVE_BATT_CYC(20), .SAVE_FLASH_CYC(40)) i_hce_host_cmd_exec (
    .pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .save_inhibit_jumper(sv_inh), .restore_inhibit_jumper(rs_inh), .cs_fault_code(fault),
    .line_valid(lvalid), .line_kind(lkind), .line_exec(lexec), .motion_run(mrun), .step_mode(smode),
    .logic_prog_active(active), .bg_hold(bgh), .cmd_ack(ack));
  hce_eng_model i_hce_eng_model (.pclk, .presetn, .prog(32'h5555_3490), .line_exec(lexec),
    .line_valid(lvalid), .line_kind(lkind), .done_cnt(ncnt));
  always #25 pclk = ~pclk;
  // ----------------------------------------
  // Checking and APB tasks
  // ----------------------------------------
  task close_out;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  task stop;
    failures++;
    close_out;
  endtask : stop
  task chk(input logic [31:0] seen, input logic [31:0] exp, input logic [31:0] m);
    check_count++;
    if ((seen & m) !== (exp & m))
    begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task xfer(input logic [7:0] a, input logic is_wr, input logic [31:0] d, input logic c = 1'b0);
    @(posedge pclk);
    psel    <= 1;
    penable <= 0;
    paddr   <= a;
    pwrite  <= is_wr;
    pwdata  <= d;
    want    <= c;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (!pready && n < 20);
    if (!pready)
      stop;
    rv = prdata;
    psel    <= 0;
    penable <= 0;
    want    <= 0;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1);
    q.push_back({m, x});
    xfer(a, 0, 0, 1);
  endtask : rd
  task poll(input int b, input logic v);
    k = 0;
    do
    begin
      xfer(hce_pkg::A_STAT, 0, 0);
      k++;
    end
    while (rv[b] !== v && k < 60);
    if (rv[b] !== v)
      stop;
  endtask : poll
  task wack;
    k = 0;
    while (ack !== 1'b1 && k < 100)
    begin
      @(posedge pclk);
      k++;
    end
    if (ack !== 1'b1)
      stop;
  endtask : wack
  task cmd(input logic [31:0] c);
    wr(hce_pkg::A_CMD, c);
    wack;
  endtask : cmd
  task rst;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
  endtask : rst
  // Read flag travels with the request, so a back-to-back read cannot lose it
  always @(posedge pclk)
    if (want && psel && penable && pready)
    begin
      w = q.pop_front();
      chk(prdata, w[31:0], w[63:32]);
    end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    void'($urandom(26));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    por_n   <= 1;
    @(posedge pclk);
    rd(hce_pkg::A_CFG, 0);
    rd(8'h3C, 0);
    chk(pslverr, 1, 1);
    $display("end regs");
    for (int s = 0; s < 3; s++)
      for (int h = 0; h < 2; h++)
      begin
        for (int i = 0; i < 2; i++)
        begin
          xs[i] = 24'($urandom);
          ys[i] = 24'($urandom);
          wr(hce_pkg::A_ADDR, 32'(63 + i));
          wr(hce_pkg::A_MEMX, {8'h0, xs[i]});
          wr(hce_pkg::A_MEMY, {8'h0, ys[i]});
        end
        wr(hce_pkg::A_ADDR, 32'd63);
        wr(hce_pkg::A_CMD, {21'h0, 3'h1, h[0], s[1:0], 5'(s == 1 ? 0 : 2)});
        for (int i = 0; i < (s == 1 ? 1 : 2); i++)
        begin
          poll(3, 1);
          r = (s == 2) ? {xs[i], ys[i]} : {24'h0, (s == 1) ? ys[i] : xs[i]};
          e = h ? {16'h0, r} : (s == 2) ? {{16{r[47]}}, r} : {{40{r[23]}}, r[23:0]};
          rd(hce_pkg::A_RPLHI, e[63:32]);
          rd(hce_pkg::A_RPLLO, e[31:0]);
        end
        wack;
      end
    $display("end peek");
    wr(hce_pkg::A_CFG, 32'h10);
    wr(hce_pkg::A_MASK, 6);
    cmd(32'h400);
    wr(hce_pkg::A_MASK, 3);
    cmd(32'h300);
    wr(hce_pkg::A_MASK, 0);
    wr(hce_pkg::A_RANGE, 32'h1_1F00);
    cmd(32'h200);
    rd(hce_pkg::A_PRUN, 3);
    wr(hce_pkg::A_CFG, 32'h30);
    wr(hce_pkg::A_RANGE, 0);
    wr(hce_pkg::A_MASK, 4);
    cmd(32'h200);
    rd(hce_pkg::A_BUFQ, 4);
    chk(active, 3, '1);
    wr(hce_pkg::A_CFG, 0);
    repeat (3) @(posedge pclk);
    chk(active, 0, '1);
    $display("end resume");
    fault <= 5'h0B;
    for (int m = 0; m < 4; m++)
    begin
      wr(hce_pkg::A_CFG, 32'(m * 2));
      cmd(32'h600);
      rd(hce_pkg::A_STAT, m[0] ? 32'h1604 : 32'h4, 32'h3E04);
    end
    fault <= 5'h0;
    wr(hce_pkg::A_CFG, 0);
    cmd(32'h600);
    @(posedge pclk);
    chk(ncnt, 3, '1);
    wr(hce_pkg::A_CFG, 1);
    cmd(32'h600);
    @(posedge pclk);
    chk(ncnt, 7, '1);
    cmd(32'h600);
    @(posedge pclk);
    chk(ncnt, 8, '1);
    chk({smode, mrun}, 2, 3);
    wr(hce_pkg::A_CMD, 32'h500);
    repeat (4) @(posedge pclk);
    cmd(32'h600);
    chk(smode, 1, 1);
    poll(0, 0);
    $display("end step");
    sv_inh <= 1;
    wr(hce_pkg::A_CFG, 32'h2);
    cmd(32'h700);
    rd(hce_pkg::A_STAT, 32'h3E04, 32'h3E04);
    sv_inh <= 0;
    for (int v = 1; v >= 0; v--)
    begin
      wr(hce_pkg::A_CFG, v ? 32'h52 : 32'h12);
      wr(hce_pkg::A_CMD, 32'h700);
      k = 0;
      while (ack !== 1'b1 && k < 100)
      begin
        @(posedge pclk);
        k++;
        if (k == 5)
          chk({bgh, |active}, 2, 3);
      end
      chk({ack, 1'(k >= (v ? 40 : 20))}, 3, 3);
      wr(hce_pkg::A_CFG, 0);
      rst;
      rd(hce_pkg::A_CFG, v ? 32'h52 : 32'h12);
      rd(hce_pkg::A_PRUN, v ? 3 : 0);
    end
    wr(hce_pkg::A_CFG, 0);
    rs_inh <= 1;
    rst;
    rd(hce_pkg::A_CFG, 0);
    $display("end save");
    @(posedge pclk);
    close_out;
  end
endmodule : tb_top
